// ===== ebc_regs.svh
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH
// How it works
// - Handshake off: wait count alone times cycle
// - Handshake on: ready pin ends the cycle
// - Polarity 0: cycle ends on sampled low
// - Polarity 1: cycle ends on sampled high
// - Load gating off: select ignores load strobe
// - Load gating on: select only during load
// - Store gating off: select ignores store strobes
// - Store gating on: select only during store
// - Clock ratio caught only on long reset
// - Lower snapshot fields caught every reset
// - Layout 0: pins become byte store strobes
// - Select line count decode, default five
// - Segment line count decode, default two
// - Clock ratio decode to oscillator multiple
// - Disabled window runs no bus cycle
// - Window zero bus type from pins

// ****************
// Register map
// ****************
`define EBC_ADDR_SNAP 16'hf108
`define EBC_ADDR_WIN0 16'hff10
`define EBC_ADDR_STAT 16'hff20
`define EBC_NWIN 5

// ****************
// Window control fields
// ****************
`define EBC_F_CSWEN 15
`define EBC_F_CSREN 14
`define EBC_F_RDYPOL 13
`define EBC_F_RDYEN 12
`define EBC_F_BUSACT 10
`define EBC_F_BUS_TYPE_FIELD_HI 7
`define EBC_F_BUS_TYPE_FIELD_LO 6
`define EBC_F_WAIT_STATE_COUNT_HI 3
`define EBC_F_WAIT_STATE_COUNT_LO 0
`define EBC_WIN_RST 16'h0000
`define EBC_MAX_WAIT 4'hf

// ****************
// Snapshot fields
// ****************
`define EBC_S_WRC 0
`define EBC_S_SELECT_LINE_COUNT_HI 2
`define EBC_S_SELECT_LINE_COUNT_LO 1
`define EBC_S_SAL_HI 4
`define EBC_S_SAL_LO 3
`define EBC_S_CLK_HI 7
`define EBC_S_CLK_LO 5
`define EBC_SNAP_RST 8'hff
`endif

// ===== ebc_pkg.sv
`include "ebc_regs.svh"
package ebc_pkg;

   typedef enum logic [1:0] {
      EBC_IDLE = 2'b00,
      EBC_ADDR = 2'b01,
      EBC_STRB = 2'b11,
      EBC_DONE = 2'b10
   } ebc_state_t;

   typedef struct packed {
      ebc_state_t st;
      logic [`EBC_NWIN-1:0][15:0] win;
      logic [2:0] cur;
      logic wr;
      logic [1:0] be;
      logic [15:0] cfg;
      logic [3:0] cnt;
      logic busy;
      logic done;
      logic refused;
      logic [15:0] rdata;
      logic rd_n;
      logic wr_n;
      logic bhe_n;
      logic [4:0] cs_n;
      logic [7:0] seg_en;
      logic [4:0] ratio_x2;
   } ebc_top_st_t;

   typedef struct packed {
      logic cap_done;
      logic [7:0] snap;
   } ebc_snap_st_t;

   function automatic logic [4:0] ebc_cs_mask(input logic [1:0] sel);
      case (sel)
         2'b00: ebc_cs_mask = 5'h07;
         2'b01: ebc_cs_mask = 5'h03;
         2'b10: ebc_cs_mask = 5'h00;
         default: ebc_cs_mask = 5'h1f;
      endcase
   endfunction

   function automatic logic [7:0] ebc_seg_mask(input logic [1:0] sel);
      case (sel)
         2'b00: ebc_seg_mask = 8'h0f;
         2'b01: ebc_seg_mask = 8'h00;
         2'b10: ebc_seg_mask = 8'hff;
         default: ebc_seg_mask = 8'h03;
      endcase
   endfunction

   // Ratio in halves so 0.5 and 2.5 stay integral
   function automatic logic [4:0] ebc_ratio_x2(input logic [2:0] sel);
      case (sel)
         3'b000: ebc_ratio_x2 = 5'h05;
         3'b001: ebc_ratio_x2 = 5'h01;
         3'b010: ebc_ratio_x2 = 5'h14;
         3'b011: ebc_ratio_x2 = 5'h02;
         3'b100: ebc_ratio_x2 = 5'h0a;
         3'b101: ebc_ratio_x2 = 5'h04;
         3'b110: ebc_ratio_x2 = 5'h06;
         default: ebc_ratio_x2 = 5'h08;
      endcase
   endfunction

endpackage

// ===== ebc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ebc_if;
   logic load;
   logic [7:0] snap;
   logic [1:0] btyp0;
   modport src (output load, output snap, output btyp0);
   modport dst (input load, input snap, input btyp0);
endinterface
`default_nettype wire

// ===== ebc_snap.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"
module ebc_snap (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Straps
   input wire logic [15:0] i_port0,
   input wire logic i_long_rst,
   // To core
   ebc_if.src bus
);
   import ebc_pkg::*;

   ebc_snap_st_t q;
   ebc_snap_st_t next;

   // ****************
   // Capture after reset release
   // ****************
   // Reset takes the pull-up value; pins are caught one edge later
   always_comb begin
      next = q;
      if (!q.cap_done) begin
         next.cap_done = 1'b1;
         next.snap[`EBC_S_SAL_HI:0] = i_port0[12:8];
         if (i_long_rst) begin
            next.snap[`EBC_S_CLK_HI:`EBC_S_CLK_LO] = i_port0[15:13];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q <= '{cap_done: 1'b0, snap: `EBC_SNAP_RST};
      end else begin
         q <= next;
      end
   end

   assign bus.load = !q.cap_done;
   assign bus.snap = q.snap;
   assign bus.btyp0 = i_port0[7:6];

   // ****************
   // Checks
   // ****************
   property p_snap_stable;
      @(posedge i_clk) disable iff (!i_rstn)
      q.cap_done |=> $stable(q.snap);
   endproperty
   a_snap_stable: assert property (p_snap_stable)
      else $error("snapshot changed after capture");

   property p_snap_load;
      @(posedge i_clk) disable iff (!i_rstn)
      // Release edge still sees reset state, so key on the capture itself
      $rose(q.cap_done) |-> q.snap[4:0] == $past(i_port0[12:8]);
   endproperty
   a_snap_load: assert property (p_snap_load)
      else $error("lower snapshot fields not caught");

   property p_clk_short;
      @(posedge i_clk) disable iff (!i_rstn)
      (!q.cap_done && !i_long_rst) |=> q.snap[7:5] == 3'h7;
   endproperty
   a_clk_short: assert property (p_clk_short)
      else $error("clock ratio caught without long reset");
endmodule
`default_nettype wire

// ===== ebc_top.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"
module ebc_top (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Register port
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [15:0] o_rdata,
   // Strap pins
   input wire logic [15:0] i_port0,
   input wire logic i_long_rst,
   // Access requests
   input wire logic i_req,
   input wire logic [2:0] i_req_win,
   input wire logic i_req_write,
   input wire logic [1:0] i_req_be,
   output logic o_busy,
   output logic o_done,
   output logic o_refused,
   // Bus pins
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_bhe_n,
   output logic [4:0] o_cs_n,
   input wire logic i_ready,
   // Configuration outputs
   output logic [7:0] o_seg_en,
   output logic [4:0] o_ratio_x2
);
   import ebc_pkg::*;

   ebc_top_st_t q;
   ebc_top_st_t next;
   ebc_if u_if ();

   logic [15:0] win_off;
   logic win_hit;
   logic [2:0] win_idx;
   logic req_ok;
   logic layout;
   logic act;
   logic stb;
   logic gate;
   logic cs_on;
   logic rdy_seen;

   // ****************
   // Snapshot
   // ****************
   ebc_snap u_snap (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_port0(i_port0),
      .i_long_rst(i_long_rst),
      .bus(u_if.src)
   );

   // ****************
   // Address decode
   // ****************
   assign win_off = i_addr - `EBC_ADDR_WIN0;
   assign win_hit = (i_addr >= `EBC_ADDR_WIN0) && !win_off[0]
      && (win_off[15:1] < 15'(`EBC_NWIN));
   assign win_idx = win_off[3:1];

   // Window must exist and be enabled to start a cycle
   assign req_ok = (i_req_win < 3'(`EBC_NWIN))
      && q.win[i_req_win][`EBC_F_BUSACT];

   assign layout = u_if.snap[`EBC_S_WRC];

   // Ready compared against the programmed active level
   assign rdy_seen = (i_ready == q.cfg[`EBC_F_RDYPOL]);

   // ****************
   // Next state
   // ****************
   always_comb begin
      next = q;
      next.done = 1'b0;
      next.refused = 1'b0;
      act = 1'b0;
      stb = 1'b0;
      gate = 1'b0;
      cs_on = 1'b0;

      // Register writes
      if (i_we && win_hit) begin
         next.win[win_idx] = i_wdata;
      end
      // Bus type of window zero follows the pins after reset
      if (u_if.load) begin
         next.win[0][`EBC_F_BUS_TYPE_FIELD_HI:`EBC_F_BUS_TYPE_FIELD_LO] = u_if.btyp0;
      end

      // Register reads, data in the following cycle only
      next.rdata = 16'h0000;
      if (i_re) begin
         if (i_addr == `EBC_ADDR_SNAP) begin
            next.rdata = {8'h00, u_if.snap};
         end else if (win_hit) begin
            next.rdata = q.win[win_idx];
         end else if (i_addr == `EBC_ADDR_STAT) begin
            next.rdata = {8'h00, q.busy, q.st, q.cur, q.wr, i_ready};
         end
      end

      // Cycle sequencer
      case (q.st)
         EBC_IDLE: begin
            if (i_req && !req_ok) begin
               next.refused = 1'b1;
            end else if (i_req) begin
               next.st = EBC_ADDR;
               next.cur = i_req_win;
               next.wr = i_req_write;
               next.be = i_req_be;
               // Settings are frozen for the whole cycle
               next.cfg = q.win[i_req_win];
            end
         end
         EBC_ADDR: begin
            next.st = EBC_STRB;
            next.cnt = `EBC_MAX_WAIT
               - q.cfg[`EBC_F_WAIT_STATE_COUNT_HI:`EBC_F_WAIT_STATE_COUNT_LO];
         end
         EBC_STRB: begin
            if (q.cfg[`EBC_F_RDYEN]) begin
               // Wait count unused; strobes stay until ready
               if (rdy_seen) begin
                  next.st = EBC_DONE;
                  next.done = 1'b1;
               end
            end else if (q.cnt == 4'h0) begin
               next.st = EBC_DONE;
               next.done = 1'b1;
            end else begin
               next.cnt = q.cnt - 4'h1;
            end
         end
         EBC_DONE: begin
            // One idle cycle between accesses
            next.st = EBC_IDLE;
         end
         default: begin
            next.st = EBC_IDLE;
         end
      endcase
      next.busy = (next.st != EBC_IDLE);

      // ****************
      // Pin drive
      // ****************
      act = (next.st == EBC_ADDR) || (next.st == EBC_STRB);
      stb = (next.st == EBC_STRB);
      gate = next.wr ? next.cfg[`EBC_F_CSWEN] : next.cfg[`EBC_F_CSREN];
      // Gated select follows the strobe, else the whole cycle
      cs_on = gate ? stb : act;
      next.cs_n = ~((5'h01 << next.cur)
         & ebc_cs_mask(u_if.snap[`EBC_S_SELECT_LINE_COUNT_HI:`EBC_S_SELECT_LINE_COUNT_LO])
         & {5{cs_on}});
      next.rd_n = ~(stb && !next.wr);
      if (!layout) begin
         // Byte store strobes; no byte enable on this layout
         next.wr_n = ~(stb && next.wr && next.be[0]);
         next.bhe_n = ~(stb && next.wr && next.be[1]);
      end else begin
         next.wr_n = ~(stb && next.wr);
         next.bhe_n = ~(act && next.be[1]);
      end

      // ****************
      // Configuration outputs
      // ****************
      next.seg_en = ebc_seg_mask(
         u_if.snap[`EBC_S_SAL_HI:`EBC_S_SAL_LO]);
      next.ratio_x2 = ebc_ratio_x2(
         u_if.snap[`EBC_S_CLK_HI:`EBC_S_CLK_LO]);
   end

   // ****************
   // State register
   // ****************
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q <= '0;
         q.win <= {`EBC_NWIN{`EBC_WIN_RST}};
         q.rd_n <= 1'b1;
         q.wr_n <= 1'b1;
         q.bhe_n <= 1'b1;
         q.cs_n <= 5'h1f;
         q.seg_en <= 8'h03;
         q.ratio_x2 <= 5'h08;
      end else begin
         q <= next;
      end
   end

   // ****************
   // Outputs
   // ****************
   assign o_rdata = q.rdata;
   assign o_busy = q.busy;
   assign o_done = q.done;
   assign o_refused = q.refused;
   assign o_rd_n = q.rd_n;
   assign o_wr_n = q.wr_n;
   assign o_bhe_n = q.bhe_n;
   assign o_cs_n = q.cs_n;
   assign o_seg_en = q.seg_en;
   assign o_ratio_x2 = q.ratio_x2;

   // ****************
   // Checks
   // ****************
   property p_refuse;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_IDLE && i_req && !req_ok)
         |=> (q.refused && q.st == EBC_IDLE && q.cs_n == 5'h1f);
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("disabled window started a cycle");

   property p_wait_end;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_STRB && !q.cfg[`EBC_F_RDYEN] && q.cnt == 4'h0)
         |=> (q.st == EBC_DONE && q.done && q.rd_n && q.wr_n);
   endproperty
   a_wait_end: assert property (p_wait_end)
      else $error("timed cycle did not end on zero count");

   property p_wait_len;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_ADDR && !q.cfg[`EBC_F_RDYEN]
         && q.cfg[3:0] == 4'hd) |=> (q.st == EBC_STRB) [*3]
         ##1 (q.st == EBC_DONE);
   endproperty
   a_wait_len: assert property (p_wait_len)
      else $error("two wait states not three strobe cycles");

   property p_rdy_hold;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_STRB && q.cfg[`EBC_F_RDYEN]
         && i_ready != q.cfg[`EBC_F_RDYPOL])
         |=> (q.st == EBC_STRB && $stable(q.cs_n)
         && $stable(q.rd_n) && $stable(q.wr_n));
   endproperty
   a_rdy_hold: assert property (p_rdy_hold)
      else $error("cycle left before ready");

   property p_rdy_end;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_STRB && q.cfg[`EBC_F_RDYEN]
         && i_ready == q.cfg[`EBC_F_RDYPOL])
         |=> (q.st == EBC_DONE && q.done) ##1 (q.st == EBC_IDLE);
   endproperty
   a_rdy_end: assert property (p_rdy_end)
      else $error("active ready did not end cycle");

   property p_cs_load;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_ADDR && !q.wr && q.cfg[`EBC_F_CSREN])
         |-> (q.cs_n == 5'h1f);
   endproperty
   a_cs_load: assert property (p_cs_load)
      else $error("select before load strobe");

   property p_cs_store;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_ADDR && q.wr && q.cfg[`EBC_F_CSWEN])
         |-> (q.cs_n == 5'h1f) ##1 (q.cs_n != 5'h1f || q.wr_n);
   endproperty
   a_cs_store: assert property (p_cs_store)
      else $error("select outside store strobe");

   property p_cs_free;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_ADDR && !q.cfg[`EBC_F_CSREN]
         && !q.cfg[`EBC_F_CSWEN] && u_if.snap[2:1] == 2'b11)
         |-> !q.cs_n[q.cur];
   endproperty
   a_cs_free: assert property (p_cs_free)
      else $error("ungated select not driven in address phase");

   property p_byte_strb;
      @(posedge i_clk) disable iff (!i_rstn)
      (q.st == EBC_STRB && q.wr && !layout)
         |-> (q.wr_n == !q.be[0] && q.bhe_n == !q.be[1]);
   endproperty
   a_byte_strb: assert property (p_byte_strb)
      else $error("byte store strobes wrong");

   property p_cs_none;
      @(posedge i_clk) disable iff (!i_rstn)
      (u_if.snap[2:1] == 2'b10) |=> (q.cs_n == 5'h1f);
   endproperty
   a_cs_none: assert property (p_cs_none)
      else $error("select driven with no select lines");
endmodule
`default_nettype wire

// ===== ebc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Bus pins
   input wire logic i_strb_n,
   input wire logic i_pol,
   input wire logic [3:0] i_dly,
   output logic o_ready
);
   // ****
   // Ready answer
   // ****
   logic [3:0] cnt;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt <= 4'h0;
      end else begin
         cnt <= i_strb_n ? 4'h0 : cnt + 4'h1;
      end
   end
   // Inactive level outside a strobe, so a stale level never ends a cycle
   assign o_ready = (!i_strb_n && cnt >= i_dly)
      ? i_pol : !i_pol;
endmodule
`default_nettype wire

// ===== tb_ebc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ebc_top;
   logic i_clk, i_rstn, i_we, i_re, i_long_rst, i_req, i_req_write, i_ready;
   logic [15:0] i_addr, i_wdata, i_port0, o_rdata, d;
   logic [2:0] i_req_win;
   logic [1:0] i_req_be;
   logic o_busy, o_done, o_refused, o_rd_n, o_wr_n, o_bhe_n, pol, lay;
   logic sel, stb, cs1, wr_lo, bhe_lo;
   logic [4:0] o_cs_n, o_ratio_x2;
   logic [7:0] o_seg_en;
   logic [3:0] dly;
   int failures, cmp_count, n, lows, gbad;
   logic [4:0] ratio_tbl [8] = '{5'h05, 5'h01, 5'h14, 5'h02, 5'h0a, 5'h04,
      5'h06, 5'h08};
   logic [7:0] seg_tbl [4] = '{8'h0f, 8'h00, 8'hff, 8'h03};
   logic [4:0] cs_tbl [4] = '{5'h07, 5'h03, 5'h00, 5'h1f};

   ebc_top u_ebc_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
      .i_port0(i_port0), .i_long_rst(i_long_rst), .i_req(i_req),
      .i_req_win(i_req_win), .i_req_write(i_req_write),
      .i_req_be(i_req_be), .o_busy(o_busy), .o_done(o_done),
      .o_refused(o_refused), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
      .o_bhe_n(o_bhe_n), .o_cs_n(o_cs_n), .i_ready(i_ready),
      .o_seg_en(o_seg_en), .o_ratio_x2(o_ratio_x2));

   ebc_mem_model u_ebc_mem_model (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_strb_n(o_rd_n & o_wr_n), .i_pol(pol), .i_dly(dly),
      .o_ready(i_ready));

   // ****
   // Shared tasks
   // ****
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic do_reset(input logic [15:0] s, input logic lng);
      i_rstn <= 1'b0;
      i_port0 <= s;
      i_long_rst <= lng;
      lay = s[8];
      repeat (8) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_clk);
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
      @(posedge i_clk);
      i_we <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_we <= 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] a);
      @(posedge i_clk);
      i_re <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_re <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   // Samples every cycle from address phase until done or refusal
   task automatic access(input logic [2:0] w, input logic wr,
         input logic [1:0] be);
      @(posedge i_clk);
      i_req <= 1'b1;
      i_req_win <= w;
      i_req_write <= wr;
      i_req_be <= be;
      @(posedge i_clk);
      i_req <= 1'b0;
      n = 0;
      lows = 0;
      gbad = 0;
      wr_lo = 1'b0;
      bhe_lo = 1'b0;
      #1;
      while (o_done !== 1'b1 && o_refused !== 1'b1) begin
         sel = |(~o_cs_n & (5'h01 << w));
         stb = wr ? (!o_wr_n || (!lay && !o_bhe_n)) : !o_rd_n;
         if (n == 0) begin
            cs1 = sel;
         end
         if (stb) begin
            lows++;
         end
         if (sel != stb) begin
            gbad++;
         end
         wr_lo = wr_lo | !o_wr_n;
         bhe_lo = bhe_lo | !o_bhe_n;
         n++;
         if (n > 40) begin
            failures++;
            complete_run();
         end
         @(posedge i_clk);
         #1;
      end
   endtask

   // ****
   // Scenarios
   // ****
   task automatic s_straps();
      logic [15:0] s;
      for (int k = 0; k < 8; k++) begin
         s = {k[2:0], k[1:0], k[1:0], k[0], k[1:0], 6'h00};
         do_reset(s, 1'b1);
         rd_reg(16'hf108);
         check(d, {8'h00, s[15:8]});
         check(o_ratio_x2, ratio_tbl[k]);
         check(o_seg_en, seg_tbl[k[1:0]]);
         rd_reg(16'hff10);
         check(d, {8'h00, k[1:0], 6'h00});
      end
      do_reset(16'h1b00, 1'b0);
      i_port0 <= 16'h0000;
      wr_reg(16'hf108, 16'h0000);
      rd_reg(16'hf108);
      check(d, 16'h00fb);
      check(o_ratio_x2, 5'h08);
      rd_reg(16'hff30);
      check(d, 16'h0000);
   endtask

   task automatic s_timed();
      do_reset(16'hff00, 1'b1);
      pol = 1'b1;
      dly = 4'h0;
      wr_reg(16'hff12, 16'h040d);
      rd_reg(16'hff12);
      check(d, 16'h040d);
      access(3'd1, 1'b0, 2'b11);
      check(o_busy, 1'b1);
      check(16'(n), 16'd4);
      check(16'(lows), 16'd3);
      access(3'd1, 1'b1, 2'b01);
      check({wr_lo, bhe_lo}, 2'b10);
      access(3'd1, 1'b1, 2'b10);
      check({wr_lo, bhe_lo}, 2'b11);
      access(3'd2, 1'b0, 2'b11);
      check(o_refused, 1'b1);
      access(3'd5, 1'b0, 2'b11);
      check(o_refused, 1'b1);
   endtask

   task automatic s_handshake();
      for (int p = 0; p < 2; p++) begin
         pol = p[0];
         wr_reg(16'hff12, {2'b00, p[0], 3'b101, 10'h000});
         dly = 4'h3;
         access(3'd1, 1'b0, 2'b11);
         check(16'(n), 16'd5);
         check(16'(lows), 16'd4);
         dly = 4'h0;
         access(3'd1, 1'b0, 2'b11);
         check(16'(n), 16'd2);
      end
      // Idle, last window 1 read, ready inactive low at polarity 1
      rd_reg(16'hff20);
      check(d, 16'h0004);
   endtask

   task automatic s_gating();
      do_reset(16'hfe00, 1'b1);
      wr_reg(16'hff16, 16'hc40e);
      wr_reg(16'hff18, 16'h040e);
      access(3'd3, 1'b0, 2'b11);
      check(cs1, 1'b0);
      check(16'(gbad), 16'h0000);
      access(3'd3, 1'b1, 2'b11);
      check(16'(gbad), 16'h0000);
      access(3'd4, 1'b1, 2'b01);
      check(cs1, 1'b1);
      check({wr_lo, bhe_lo}, 2'b10);
      access(3'd4, 1'b1, 2'b10);
      check({wr_lo, bhe_lo}, 2'b01);
      access(3'd4, 1'b0, 2'b11);
      check(cs1, 1'b1);
   endtask

   task automatic s_select_count();
      for (int k = 0; k < 4; k++) begin
         do_reset({5'h1f, k[1:0], 1'b1, 8'h00}, 1'b1);
         for (int w = 0; w < 5; w++) begin
            wr_reg(16'hff10 + 16'(2 * w), 16'h040f);
            access(w[2:0], 1'b0, 2'b11);
            check(cs1, cs_tbl[k][w]);
         end
      end
   endtask

   // ****
   // Main sequence
   // ****
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   initial begin
      {i_rstn, i_we, i_re, i_long_rst, i_req, i_req_write} = 6'h00;
      i_addr = 16'h0000;
      i_wdata = 16'h0000;
      i_port0 = 16'h0000;
      i_req_win = 3'h0;
      i_req_be = 2'h0;
      pol = 1'b0;
      dly = 4'h0;
      lay = 1'b1;
      failures = 0;
      cmp_count = 0;
      s_straps();
      s_timed();
      s_handshake();
      s_gating();
      s_select_count();
      complete_run();
   end
endmodule
`default_nettype wire
